// ===== hw/sdpr_defines.svh
// widths, reset values and encodings for one synchronous dual-port ram port
`ifndef SDPR_DEFINES_SVH
`define SDPR_DEFINES_SVH

`define SDPR_ADDR_W     16
`define SDPR_DATA_W     8
`define SDPR_ADDR_ZERO  16'h0000
`define SDPR_DATA_ZERO  8'h00
`define SDPR_ADDR_ONE   16'h0001
`define SDPR_RW_READ    1'h1

`endif

// ===== hw/sdpr_pkg.sv
// types shared by the ram port and its address counter
`include "sdpr_defines.svh"

package sdpr_pkg;

  typedef logic [`SDPR_ADDR_W-1:0] sdpr_addr_t;
  typedef logic [`SDPR_DATA_W-1:0] sdpr_data_t;

  // output timing of the port, fixed by the strap
  typedef enum logic
  {
    SDPR_FLOW,
    SDPR_PIPE
  } sdpr_mode_t;

endpackage

// ===== hw/sdpr_addr_counter.sv
// internal address selection: external load, counter advance, hold and clear
`timescale 1ns/1ps
`default_nettype none
`include "sdpr_defines.svh"

module sdpr_addr_counter
  import sdpr_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  // registered port controls
  input  wire sdpr_addr_t ext_addr_in,
  input  wire logic       address_strobe_n_in,
  input  wire logic       counter_advance_n_in,
  input  wire logic       counter_clear_n_in,
  // address used by the current access
  output sdpr_addr_t      addr_out
);

  sdpr_addr_t count_reg;
  sdpr_addr_t count_next;
  sdpr_addr_t addr_now;

  // clear beats load, load beats advance; the clear cycle itself uses zero
  always_comb
  begin
    if (!counter_clear_n_in)
      addr_now = `SDPR_ADDR_ZERO; // RL10
    else if (!address_strobe_n_in)
      addr_now = ext_addr_in; // RL8
    else if (!counter_advance_n_in)
      addr_now = sdpr_addr_t'(count_reg + `SDPR_ADDR_ONE); // RL9
    else
      addr_now = count_reg; // RL9
    count_next = addr_now;
    addr_out   = addr_now;
  end

  // counter remembers the address of the last access
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      count_reg <= `SDPR_ADDR_ZERO;
    else
      count_reg <= count_next;
  end

endmodule
`default_nettype wire

// ===== hw/sdpr_port.sv
// one port of a synchronous dual-port static ram: input registers and output control
//
// Function
// RL1 - strap high selects pipelined output timing
// RL2 - strap low selects flow-through output timing
// RL3 - controller keeps the strap static always; the bench changes it, but only while reset is held
// RL4 - output enable acts asynchronously, strap static
// RL5 - all other inputs registered on clock
// RL6 - deselect floats outputs after next edge
// RL7 - strobe low loads address every edge
// RL8 - internal address: external or counter
// RL9 - advance increments, otherwise address holds
// RL10 - counter clear accesses zero, no dead cycle
// RL11 - pipelined needs two selected cycles to reactivate
// RL12 - pipelined read data one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "sdpr_defines.svh"

module sdpr_port
  import sdpr_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  // static output timing strap, asynchronous
  input  wire logic       latency_mode_select_in,
  // synchronous port controls
  input  wire sdpr_addr_t addr_in,
  input  wire logic       rw_in,
  input  wire logic       chip_select_active_low_in,
  input  wire logic       chip_select_active_high_in,
  input  wire logic       address_strobe_n_in,
  input  wire logic       counter_advance_n_in,
  input  wire logic       counter_clear_n_in,
  // asynchronous output enable, active low
  input  wire logic       output_enable_n_in,
  // two-way data pin split into three signals
  input  wire sdpr_data_t data_in,
  output sdpr_data_t      data_out,
  output logic            data_oe_out,
  // memory array side
  output sdpr_addr_t      arr_addr_out,
  output logic            arr_wr_out,
  output sdpr_data_t      arr_wdata_out,
  input  wire sdpr_data_t arr_rdata_in
);

  // input registers
  sdpr_addr_t addr_reg,   addr_next;
  sdpr_data_t din_reg,    din_next;
  logic       rw_reg,     rw_next;
  logic       ce_n_reg,   ce_n_next;
  logic       ce_reg,     ce_next;
  logic       ads_n_reg,  ads_n_next;
  logic       cnt_n_reg,  cnt_n_next;
  logic       clr_n_reg,  clr_n_next;
  // strap synchroniser
  logic       mode_s1_reg, mode_s1_next;
  logic       mode_s2_reg, mode_s2_next;
  // output path
  sdpr_data_t stage_reg,  stage_next;
  sdpr_data_t dout_reg,   dout_next;
  logic       rd1_reg,    rd1_next;
  logic       drv_reg,    drv_next;

  sdpr_mode_t mode;
  logic       sel_now;
  logic       rd_now;

  // every synchronous pin is taken once at the rising edge
  always_comb
  begin
    addr_next    = addr_in; // RL5
    din_next     = data_in;
    rw_next      = rw_in;
    ce_n_next    = chip_select_active_low_in;
    ce_next      = chip_select_active_high_in;
    ads_n_next   = address_strobe_n_in; // RL7
    cnt_n_next   = counter_advance_n_in;
    clr_n_next   = counter_clear_n_in;
    // strap is a dc level but still crosses in through two flops
    mode_s1_next = latency_mode_select_in;
    mode_s2_next = mode_s1_reg;
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      addr_reg    <= `SDPR_ADDR_ZERO;
      din_reg     <= `SDPR_DATA_ZERO;
      rw_reg      <= `SDPR_RW_READ;
      ce_n_reg    <= 1'h1;
      ce_reg      <= 1'h0;
      ads_n_reg   <= 1'h1;
      cnt_n_reg   <= 1'h1;
      clr_n_reg   <= 1'h1;
      // strap keeps shifting through reset so the mode has settled when reset lifts
      mode_s1_reg <= mode_s1_next;
      mode_s2_reg <= mode_s2_next;
    end
    else
    begin
      addr_reg    <= addr_next;
      din_reg     <= din_next;
      rw_reg      <= rw_next;
      ce_n_reg    <= ce_n_next;
      ce_reg      <= ce_next;
      ads_n_reg   <= ads_n_next;
      cnt_n_reg   <= cnt_n_next;
      clr_n_reg   <= clr_n_next;
      mode_s1_reg <= mode_s1_next;
      mode_s2_reg <= mode_s2_next;
    end
  end

  // address of the current access
  sdpr_addr_counter u_counter
  (
    .clock_in             (clock_in),
    .nrst_in              (nrst_in),
    .ext_addr_in          (addr_reg),
    .address_strobe_n_in  (ads_n_reg),
    .counter_advance_n_in (cnt_n_reg),
    .counter_clear_n_in   (clr_n_reg),
    .addr_out             (arr_addr_out)
  );

  // access decode from the registered enables
  assign mode          = mode_s2_reg ? SDPR_PIPE : SDPR_FLOW;
  assign sel_now       = !ce_n_reg && ce_reg;
  assign rd_now        = sel_now && (rw_reg == `SDPR_RW_READ);
  assign arr_wr_out    = sel_now && (rw_reg != `SDPR_RW_READ); // RL5
  assign arr_wdata_out = din_reg;

  // output path: flow-through loads the array word straight into the output
  // flop, pipelined passes it through one more register first
  always_comb
  begin
    stage_next = arr_rdata_in;
    rd1_next   = rd_now;
    case (mode)
      SDPR_FLOW:
      begin
        dout_next = arr_rdata_in; // RL2
        drv_next  = rd_now; // RL6
      end
      SDPR_PIPE:
      begin
        dout_next = stage_reg; // RL12
        drv_next  = rd1_reg && sel_now; // RL11
      end
      default:
      begin
        dout_next = dout_reg;
        drv_next  = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      stage_reg <= `SDPR_DATA_ZERO;
      dout_reg  <= `SDPR_DATA_ZERO;
      rd1_reg   <= 1'h0;
      drv_reg   <= 1'h0;
    end
    else
    begin
      stage_reg <= stage_next; // RL1
      dout_reg  <= dout_next;
      rd1_reg   <= rd1_next;
      drv_reg   <= drv_next;
    end
  end

  // output enable bypasses the clock so an asynchronous bus can release the pins
  assign data_out    = dout_reg;
  assign data_oe_out = drv_reg && !output_enable_n_in; // RL4

  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  a_clear_hits_zero: assert property ( // RL10
    !clr_n_reg |-> arr_addr_out == `SDPR_ADDR_ZERO)
    else $error("counter clear did not access address zero");

  a_strobe_loads_addr: assert property ( // RL8
    clr_n_reg && !ads_n_reg |-> arr_addr_out == addr_reg)
    else $error("address strobe did not select external address");

  a_strobe_every_edge: assert property ( // RL7
    counter_clear_n_in && !address_strobe_n_in |=> arr_addr_out == $past(addr_in))
    else $error("external address not loaded on clock edge");

  a_counter_steps: assert property ( // RL9
    $past(nrst_in) && clr_n_reg && ads_n_reg && !cnt_n_reg
      |-> arr_addr_out == sdpr_addr_t'($past(arr_addr_out) + `SDPR_ADDR_ONE))
    else $error("counter advance did not increment address");

  a_counter_holds: assert property ( // RL9
    $past(nrst_in) && clr_n_reg && ads_n_reg && cnt_n_reg
      |-> $stable(arr_addr_out))
    else $error("address changed while counter held");

  a_write_registered: assert property ( // RL5
    !chip_select_active_low_in && chip_select_active_high_in && !rw_in
      |=> arr_wr_out && arr_wdata_out == $past(data_in))
    else $error("write not registered on next edge");

  a_deselect_floats: assert property ( // RL6
    chip_select_active_low_in || !chip_select_active_high_in |-> ##2 !data_oe_out)
    else $error("outputs still driven after deselect");

  a_oe_async_off: assert property ( // RL4
    output_enable_n_in |-> !data_oe_out)
    else $error("output driven with output enable high");

  a_flow_latency: assert property ( // RL2
    mode == SDPR_FLOW && rd_now |=> data_out == $past(arr_rdata_in))
    else $error("flow-through data not one cycle after access");

  a_pipe_latency: assert property ( // RL12
    mode == SDPR_PIPE && rd_now |-> ##2 data_out == $past(arr_rdata_in, 2))
    else $error("pipelined data not two cycles after access");

  a_pipe_reselect: assert property ( // RL11
    mode == SDPR_PIPE && !rd1_reg |=> !drv_reg)
    else $error("pipelined output reactivated after one cycle");

endmodule
`default_nettype wire

// ===== tb/sdpr_array_model.sv
// behavioural memory array behind the ram port
`timescale 1ns/1ps
`default_nettype none

module sdpr_array_model
  import sdpr_pkg::*;
(
  // clock
  input  wire logic       clock_in,
  // access from the port
  input  wire sdpr_addr_t arr_addr_in,
  input  wire logic       arr_wr_in,
  input  wire sdpr_data_t arr_wdata_in,
  output sdpr_data_t      arr_rdata_out
);
  sdpr_data_t mem [0:65535];

  // unwritten cells hold a fill no test writes, so stale data never matches
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h5A;
  end

  // write strobe stands one cycle, committed at its closing edge
  always @(posedge clock_in)
  begin
    if (arr_wr_in === 1'b1)
      mem[arr_addr_in] <= arr_wdata_in;
  end

  // combinational read, as the port expects data within the access cycle
  assign arr_rdata_out = mem[arr_addr_in];
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for one ram port and its array model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sdpr_pkg::*;
  logic       clk, nrst, strap, rw, cs_l, cs_h, strb_n, adv_n, clr_n, oe_n, oe, wr;
  sdpr_addr_t addr, aaddr;
  sdpr_data_t din, dout, rdata, wdata;
  int         bad_count, checked;

  sdpr_port i_sdpr_port (.clock_in(clk), .nrst_in(nrst), .latency_mode_select_in(strap),
    .addr_in(addr), .rw_in(rw), .chip_select_active_low_in(cs_l),
    .chip_select_active_high_in(cs_h), .address_strobe_n_in(strb_n),
    .counter_advance_n_in(adv_n), .counter_clear_n_in(clr_n), .output_enable_n_in(oe_n),
    .data_in(din), .data_out(dout), .data_oe_out(oe), .arr_addr_out(aaddr),
    .arr_wr_out(wr), .arr_wdata_out(wdata), .arr_rdata_in(rdata));
  sdpr_array_model i_sdpr_array_model (.clock_in(clk), .arr_addr_in(aaddr),
    .arr_wr_in(wr), .arr_wdata_in(wdata), .arr_rdata_out(rdata));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one pin cycle, driven at the falling edge; returns at the next falling edge, half a cycle after the sampling edge
  task automatic cyc(input logic sel, r, s_n, a_n, c_n, input sdpr_addr_t a);
    cs_h = sel;
    cs_l = ~sel;
    rw = r;
    strb_n = s_n;
    adv_n = a_n;
    clr_n = c_n;
    addr = a;
    din = a[7:0] ^ 8'hC3;
    @(negedge clk);
  endtask

  // strap only moves while reset is held, so it is static in operation
  task automatic run_reset(input logic m);
    nrst = 1'b0;
    strap = m;
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
    // with the cycle above this makes twenty rising edges in reset
    repeat (19) @(negedge clk);
    check("oe after reset", oe, 1'b0);
    check("wr after reset", wr, 1'b0);
    nrst = 1'b1;
  endtask

  // back-to-back writes, then a deselected write that must not reach the array
  task automatic t_write();
    sdpr_addr_t a [3] = '{16'h0010, 16'h1234, 16'hFFFF};
    for (int i = 0; i < 3; i++)
    begin
      cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, a[i]);
      check("wr strobe", wr, 1'b1);
      check("wr addr", aaddr, a[i]);
      check("wr data", wdata, a[i][7:0] ^ 8'hC3);
    end
    cyc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0010);
    check("deselected wr", wr, 1'b0);
  endtask

  // four back-to-back reads of the addresses t_write wrote, latency lat
  task automatic t_burst(input int lat);
    sdpr_addr_t a [4] = '{16'h1234, 16'h0010, 16'hFFFF, 16'h1234};
    for (int i = 0; i < 5; i++)
    begin
      cyc(i < 4, 1'b1, 1'b0, 1'b1, 1'b1, a[i % 4]);
      check("drive", oe, i >= lat);
      if (i >= lat)
        check("rd data", dout, a[i - lat][7:0] ^ 8'hC3);
    end
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
    check("deselect float", oe, 1'b0);
    // a lone selected read must not turn the pipelined drive on
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0010);
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0010);
    check("lone read", oe, lat == 1);
  endtask

  // a held read keeps the pins live while output enable moves between clock edges
  task automatic t_oe_async(input int lat);
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h1234);
    repeat (lat) cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h7777);
    check("held drive", oe, 1'b1);
    check("held data", dout, 8'hF7);
    oe_n = 1'b1;
    #1;
    check("oe_n async off", oe, 1'b0);
    @(negedge clk);
    oe_n = 1'b0;
    #1;
    check("oe_n async on", oe, 1'b1);
    @(negedge clk);
    check("held data late", dout, 8'hF7);
    repeat (2) cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
    check("held deselect float", oe, 1'b0);
  endtask

  // either enable alone deselects; the junk byte must never reach the array
  task automatic t_enables();
    for (int k = 0; k < 2; k++)
    begin
      rw = 1'b0;
      strb_n = 1'b0;
      adv_n = 1'b1;
      clr_n = 1'b1;
      addr = 16'h0010;
      din = 8'h00;
      cs_l = k[0];
      cs_h = k[0];
      @(negedge clk);
      check("one enable off", wr, 1'b0);
    end
  endtask

  // load, advance, hold, clear with a write in the same cycle
  task automatic t_counter();
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h00FF);
    check("load", aaddr, 16'h00FF);
    cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'h7777);
    check("advance", aaddr, 16'h0100);
    cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h7777);
    check("hold", aaddr, 16'h0100);
    cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h4321);
    check("clear addr", aaddr, 16'h0000);
    check("clear wr", wr, 1'b1);
    cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'h7777);
    check("after clear", aaddr, 16'h0001);
  endtask

  // main sequence: flow-through first, then pipelined
  initial
  begin
    bad_count = 0;
    checked = 0;
    oe_n = 1'b0;
    run_reset(1'b0);
    t_write();
    t_enables();
    t_burst(1);
    t_oe_async(1);
    t_counter();
    run_reset(1'b1);
    t_burst(2);
    t_oe_async(2);
    print_verdict();
  end

  // watchdog against a hung run
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule

`default_nettype wire
